//--- logic/port_cap2_regs.sv
// port_cap2_regs: second-generation capability and control registers
// assumes: hresetn is the fundamental reset, hot_reset a one-cycle
// pulse on hclk; link and conversion inputs are on hclk as well
//
// Functional notes
// - alternate routing forward supported resets to one, lockable.
// - with supported clear, forward enable reads zero and drops writes.
// - upstream port reads forward supported as zero always.
// - forward enable stops forcing device number zero on conversion.
// - forward enable resets zero, writable downstream, zero upstream.
// - downstream target speed caps speeds advertised in training.
// - target speed codes 1 and 2, resets to 2, sticky.
// - target speed also selects the compliance mode speed.
// - autonomous speed disable always reads zero.
// - software retrain speed changes proceed regardless of that bit.
// - downstream de-emphasis select: 0 gives -6.0 dB, 1 gives -3.5 dB.
// - upstream de-emphasis select only sets the advertised preference.
// - de-emphasis select has no effect at 2.5 GT/s or low swing.
// - new de-emphasis reaches the line only in a permitted state.
// - device status two and link capabilities two read all zero.
//
// The AHB-Lite register port is this design's own decision.
`include "port_cap2_defines.svh"
`default_nettype none
module port_cap2_regs
  import port_cap2_pkg::*;
(
  // clock and resets
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hot_reset,
  // port strap
  input  wire logic                     port_is_upstream,
  // register bus
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  // configuration request conversion
  input  wire logic                     conv_valid,
  input  wire logic [4:0]               conv_dev,
  input  wire logic [2:0]               conv_func,
  output logic                          conv_valid_q,
  output logic [4:0]                    conv_dev_q,
  output logic [2:0]                    conv_func_q,
  output logic                          ari_fwd_enable,
  // link training
  input  wire logic                     retrain_req,
  input  wire logic                     deemph_window,
  input  wire logic                     link_gen1,
  input  wire logic                     low_swing,
  output port_cap2_pkg::speed_t         speed_adv_cap_q,
  output port_cap2_pkg::speed_t         compliance_speed_q,
  output logic                          compliance_entry_q,
  output logic                          speed_change_req_q,
  output port_cap2_pkg::speed_t         speed_change_target_q,
  output logic                          tx_deemph_35db_q,
  output logic                          tx_deemph_active_q,
  output logic                          deemph_pref_q
);
  import port_cap2_pkg::*;

  // ****************************************************************
  // bus front end
  // ****************************************************************
  logic      rd_stb;
  reg_sel_t  rd_sel;
  logic      wr_stb;
  reg_sel_t  wr_sel;
  logic      unused_size;

  assign unused_size = ^hsize;

  ahb_reg_port ahb_reg_port_inst (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rd_stb    (rd_stb),
    .rd_sel    (rd_sel),
    .wr_stb    (wr_stb),
    .wr_sel    (wr_sel)
  );

  // ****************************************************************
  // storage
  // ****************************************************************
  logic       ari_sup_q;
  logic       ari_en_q;
  speed_t     tspeed_q;
  logic       compl_q;
  logic       deemph_q;
  logic       lock_q;
  logic       wr_dcap2;
  logic       wr_dctl2;
  logic       wr_lctl2;
  logic       wr_lock;
  logic       ari_sup_rd;
  logic [31:0] hrdata_q;

  assign wr_dcap2 = wr_stb && (wr_sel == SEL_DCAP2);
  assign wr_dctl2 = wr_stb && (wr_sel == SEL_DCTL2);
  assign wr_lctl2 = wr_stb && (wr_sel == SEL_LCTL2);
  assign wr_lock  = wr_stb && (wr_sel == SEL_LOCK);

  // upstream hides the capability whatever is stored
  assign ari_sup_rd = ari_sup_q && !port_is_upstream;

  // lock: set by firmware, held until any reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= `RST_LOCK;
    end else if (hot_reset) begin
      lock_q <= `RST_LOCK;
    end else if (wr_lock && hwdata[`BIT_LOCK]) begin
      lock_q <= 1'b1;
    end
  end

  // forward supported: writable until locked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ari_sup_q <= `RST_ARI_SUP;
    end else if (hot_reset) begin
      ari_sup_q <= `RST_ARI_SUP;
    end else if (wr_dcap2 && !lock_q) begin
      ari_sup_q <= hwdata[`BIT_ARI_SUP];
    end
  end

  // forward enable: cleared, not just masked, so a later re-enable
  // of the capability does not revive an old setting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ari_en_q <= `RST_ARI_EN;
    end else if (hot_reset || port_is_upstream || !ari_sup_q) begin
      ari_en_q <= `RST_ARI_EN;
    end else if (wr_dctl2) begin
      ari_en_q <= hwdata[`BIT_ARI_EN];
    end
  end

  // sticky fields: only the fundamental reset touches them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tspeed_q <= `RST_TSPEED;
      compl_q  <= `RST_COMPL;
    end else if (wr_lctl2) begin
      tspeed_q <= hwdata[`MSB_TSPEED:`LSB_TSPEED];
      compl_q  <= hwdata[`BIT_COMPL];
    end
  end

  // de-emphasis select: lockable like the capability
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deemph_q <= `RST_DEEMPH;
    end else if (hot_reset) begin
      deemph_q <= `RST_DEEMPH;
    end else if (wr_lctl2 && !lock_q) begin
      deemph_q <= hwdata[`BIT_DEEMPH];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  function automatic logic [31:0] rd_word(input reg_sel_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (s)
      SEL_DCAP2: w[`BIT_ARI_SUP] = ari_sup_rd;
      SEL_DCTL2: w[`BIT_ARI_EN] = ari_en_q;
      SEL_LCTL2: begin
        w[`MSB_TSPEED:`LSB_TSPEED] = tspeed_q;
        w[`BIT_COMPL]              = compl_q;
        w[`BIT_ASD]                = `VAL_ASD;
        w[`BIT_DEEMPH]             = deemph_q;
      end
      SEL_LOCK:  w[`BIT_LOCK] = lock_q;
      default:   w = 32'h0000_0000;
    endcase
    rd_word = w;
  endfunction : rd_word

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_stb) begin
      hrdata_q <= rd_word(rd_sel);
    end
  end

  assign hrdata = hrdata_q;

  // ****************************************************************
  // configuration request conversion
  // ****************************************************************
  assign ari_fwd_enable = ari_en_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_valid_q <= 1'b0;
      conv_dev_q   <= 5'h00;
      conv_func_q  <= 3'h0;
    end else begin
      conv_valid_q <= conv_valid;
      if (conv_valid) begin
        conv_dev_q  <= ari_en_q ? conv_dev : 5'h00;
        conv_func_q <= conv_func;
      end
    end
  end

  // ****************************************************************
  // link speed control
  // ****************************************************************
  // upstream advertises everything it supports
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_adv_cap_q <= `RST_TSPEED;
    end else begin
      speed_adv_cap_q <= port_is_upstream ? `SPEED_GEN2 : tspeed_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compliance_speed_q <= `RST_TSPEED;
      compliance_entry_q <= `RST_COMPL;
    end else begin
      compliance_speed_q <= tspeed_q;
      compliance_entry_q <= compl_q;
    end
  end

  // no autonomous gate here: the disable bit is constant zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_change_req_q    <= 1'b0;
      speed_change_target_q <= `RST_TSPEED;
    end else begin
      speed_change_req_q <= retrain_req;
      if (retrain_req) begin
        speed_change_target_q <= tspeed_q;
      end
    end
  end

  // ****************************************************************
  // de-emphasis
  // ****************************************************************
  deemph_apply deemph_apply_inst (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .sel         (deemph_q),
    .upstream    (port_is_upstream),
    .window      (deemph_window),
    .link_gen1   (link_gen1),
    .low_swing   (low_swing),
    .tx_35db_q   (tx_deemph_35db_q),
    .tx_active_q (tx_deemph_active_q),
    .pref_q      (deemph_pref_q)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence dcap2_rd_s;
    rd_stb && (rd_sel == SEL_DCAP2);
  endsequence

  sequence dctl2_rd_s;
    rd_stb && (rd_sel == SEL_DCTL2);
  endsequence

  sequence zero_rd_s;
    rd_stb && ((rd_sel == SEL_DSTS2) || (rd_sel == SEL_LCAP2));
  endsequence

  sequence lctl2_wr_s;
    wr_lctl2;
  endsequence

  ari_sup_up_a: assert property (
    dcap2_rd_s and port_is_upstream |=> hrdata[`BIT_ARI_SUP] == 1'b0)
    else $error("forward supported visible in upstream port");

  ari_en_gate_a: assert property (
    $past(!ari_sup_q) |-> !ari_en_q)
    else $error("forward enable set without capability");

  ari_en_up_a: assert property (
    dctl2_rd_s and $past(port_is_upstream) |=> !hrdata[`BIT_ARI_EN])
    else $error("forward enable visible in upstream port");

  conv_dev_a: assert property (
    conv_valid && !ari_en_q |=> conv_valid_q && conv_dev_q == 5'h00)
    else $error("device number not forced to zero");

  conv_pass_a: assert property (
    conv_valid && ari_en_q |=> conv_dev_q == $past(conv_dev))
    else $error("device number forced while forwarding enabled");

  adv_cap_a: assert property (
    !port_is_upstream ##1 !port_is_upstream |-> speed_adv_cap_q == $past(tspeed_q))
    else $error("advertised speed not capped by target speed");

  sticky_hot_a: assert property (
    hot_reset && !wr_lctl2 |=> tspeed_q == $past(tspeed_q) && compl_q == $past(compl_q))
    else $error("sticky field lost on hot reset");

  tspeed_wr_a: assert property (
    lctl2_wr_s |=> tspeed_q == $past(hwdata[`MSB_TSPEED:`LSB_TSPEED]) ##1
      compliance_speed_q == $past(tspeed_q))
    else $error("target speed not written or not used for compliance");

  zero_regs_a: assert property (
    zero_rd_s |=> hrdata == 32'h0000_0000)
    else $error("reserved status or capability not zero");

  asd_zero_a: assert property (
    rd_stb && (rd_sel == SEL_LCTL2) |=> !hrdata[`BIT_ASD])
    else $error("autonomous speed disable reads one");

  retrain_a: assert property (
    retrain_req |=> speed_change_req_q && speed_change_target_q == $past(tspeed_q))
    else $error("software speed change not passed on");

  deemph_hold_a: assert property (
    !deemph_window |=> $stable(tx_deemph_35db_q))
    else $error("de-emphasis changed outside permitted state");

  deemph_up_a: assert property (
    port_is_upstream |=> !tx_deemph_active_q)
    else $error("upstream port drives its own de-emphasis");

  deemph_gen1_a: assert property (
    link_gen1 || low_swing |=> !tx_deemph_active_q)
    else $error("de-emphasis active at low rate or low swing");

  lock_a: assert property (
    wr_dcap2 && lock_q |=> ari_sup_q == $past(ari_sup_q))
    else $error("locked capability changed by write");

endmodule : port_cap2_regs
`default_nettype wire

//--- logic/port_cap2_defines.svh
// port_cap2_defines.svh: offsets, field positions and reset values
// assumes: included by bare name from the logic/ sources
`ifndef PORT_CAP2_DEFINES_SVH
`define PORT_CAP2_DEFINES_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_DCAP2 30'h0000_0064
`define IDX_DCTL2 30'h0000_0068
`define IDX_DSTS2 30'h0000_006A
`define IDX_LCAP2 30'h0000_006C
`define IDX_LCTL2 30'h0000_0070
`define IDX_LOCK  30'h0000_0074

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_ARI_SUP   5
`define BIT_ARI_EN    5
`define LSB_TSPEED    0
`define MSB_TSPEED    3
`define BIT_COMPL     4
`define BIT_ASD       5
`define BIT_DEEMPH    6
`define BIT_LOCK      0

// ****************************************************************
// reset values and codes
// ****************************************************************
`define RST_ARI_SUP   1'h1
`define RST_ARI_EN    1'h0
`define RST_TSPEED    4'h2
`define RST_COMPL     1'h0
`define RST_DEEMPH    1'h0
`define RST_LOCK      1'h0
`define SPEED_GEN1    4'h1
`define SPEED_GEN2    4'h2
`define VAL_ASD       1'h0

`endif

//--- logic/port_cap2_pkg.sv
// port_cap2_pkg: types shared by the register bank and its bus port
// assumes: nothing beyond the defines header
`default_nettype none
package port_cap2_pkg;

  // one-hot register select
  typedef enum logic [6:0] {
    SEL_NONE  = 7'h01,
    SEL_DCAP2 = 7'h02,
    SEL_DCTL2 = 7'h04,
    SEL_DSTS2 = 7'h08,
    SEL_LCAP2 = 7'h10,
    SEL_LCTL2 = 7'h20,
    SEL_LOCK  = 7'h40
  } reg_sel_t;

  typedef logic [3:0] speed_t;

endpackage : port_cap2_pkg
`default_nettype wire

//--- logic/ahb_reg_port.sv
// ahb_reg_port: AHB-Lite slave front end for a word-wide register bank
// assumes: single master, word transfers, reads registered by the caller
`include "port_cap2_defines.svh"
`default_nettype none
module ahb_reg_port
  import port_cap2_pkg::*;
(
  // clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // bus
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  // to the bank
  output logic                          rd_stb,
  output port_cap2_pkg::reg_sel_t       rd_sel,
  output logic                          wr_stb,
  output port_cap2_pkg::reg_sel_t       wr_sel
);
  import port_cap2_pkg::*;

  logic      take;
  logic      wr_pend_q;
  reg_sel_t  wr_sel_q;

  function automatic reg_sel_t decode(input logic [31:0] a);
    case (a[31:2])
      `IDX_DCAP2: decode = SEL_DCAP2;
      `IDX_DCTL2: decode = SEL_DCTL2;
      `IDX_DSTS2: decode = SEL_DSTS2;
      `IDX_LCAP2: decode = SEL_LCAP2;
      `IDX_LCTL2: decode = SEL_LCTL2;
      `IDX_LOCK:  decode = SEL_LOCK;
      default:    decode = SEL_NONE;
    endcase
  endfunction : decode

  // a read behind a write waits one cycle so it sees the new value
  assign hreadyout = ~(wr_pend_q & hsel & htrans[1] & ~hwrite);
  assign hresp     = 1'b0;
  assign take      = hsel & hready & htrans[1];
  assign rd_stb    = take & ~hwrite;
  assign rd_sel    = decode(haddr);
  assign wr_stb    = wr_pend_q;
  assign wr_sel    = wr_sel_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_sel_q  <= SEL_NONE;
    end else begin
      wr_pend_q <= take & hwrite;
      if (take & hwrite) begin
        wr_sel_q <= decode(haddr);
      end
    end
  end

endmodule : ahb_reg_port
`default_nettype wire

//--- logic/deemph_apply.sv
// deemph_apply: holds the de-emphasis actually driven on the line
// assumes: window pulse comes from the link state machine, same clock
`default_nettype none
module deemph_apply (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic sel,
  input  wire logic upstream,
  input  wire logic window,
  input  wire logic link_gen1,
  input  wire logic low_swing,
  // line side
  output logic      tx_35db_q,
  output logic      tx_active_q,
  output logic      pref_q
);

  // applied selection moves only in a permitted link state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_35db_q <= 1'b0;
    end else if (window && !upstream) begin
      tx_35db_q <= sel;
    end
  end

  // no effect at the lower rate nor in low swing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_active_q <= 1'b0;
    end else begin
      tx_active_q <= !upstream && !link_gen1 && !low_swing;
    end
  end

  // advertised preference, the partner picks the real level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pref_q <= 1'b0;
    end else begin
      pref_q <= sel;
    end
  end

endmodule : deemph_apply
`default_nettype wire

//--- sim/port_cap2_regs_test.sv
// port_cap2_regs_test: register, conversion and link-control checks
// assumes: one AHB-Lite master, hready looped back from hreadyout
`include "port_cap2_defines.svh"
`default_nettype none
module port_cap2_regs_test
  import port_cap2_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************
  // signals
  // ********************************
  logic        hclk, hresetn, hot_reset, port_is_upstream, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, conv_func, conv_func_q;
  logic        hreadyout, hresp, conv_valid, conv_valid_q, ari_fwd_enable;
  logic [4:0]  conv_dev, conv_dev_q;
  logic        retrain_req, deemph_window, link_gen1, low_swing;
  logic        compliance_entry_q, speed_change_req_q;
  logic        tx_deemph_35db_q, tx_deemph_active_q, deemph_pref_q;
  speed_t      speed_adv_cap_q, compliance_speed_q, speed_change_target_q;
  int          failures, tests_run;

  localparam logic [31:0] A_DCAP2 = {`IDX_DCAP2, 2'h0};
  localparam logic [31:0] A_DCTL2 = {`IDX_DCTL2, 2'h0};
  localparam logic [31:0] A_DSTS2 = {`IDX_DSTS2, 2'h0};
  localparam logic [31:0] A_LCAP2 = {`IDX_LCAP2, 2'h0};
  localparam logic [31:0] A_LCTL2 = {`IDX_LCTL2, 2'h0};
  localparam logic [31:0] A_LOCK  = {`IDX_LOCK, 2'h0};

  port_cap2_regs port_cap2_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hot_reset(hot_reset),
    .port_is_upstream(port_is_upstream),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .conv_valid(conv_valid), .conv_dev(conv_dev), .conv_func(conv_func),
    .conv_valid_q(conv_valid_q), .conv_dev_q(conv_dev_q),
    .conv_func_q(conv_func_q), .ari_fwd_enable(ari_fwd_enable),
    .retrain_req(retrain_req), .deemph_window(deemph_window),
    .link_gen1(link_gen1), .low_swing(low_swing),
    .speed_adv_cap_q(speed_adv_cap_q), .compliance_speed_q(compliance_speed_q),
    .compliance_entry_q(compliance_entry_q),
    .speed_change_req_q(speed_change_req_q),
    .speed_change_target_q(speed_change_target_q),
    .tx_deemph_35db_q(tx_deemph_35db_q), .tx_deemph_active_q(tx_deemph_active_q),
    .deemph_pref_q(deemph_pref_q)
  );

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ********************************
  // tasks
  // ********************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // hready sampled at the rising edge, before that edge's updates land
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic write(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : write

  task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(name, exp, q);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : rchk

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : settle

  task automatic conv(input logic [4:0] dev, input logic [4:0] exp);
    @(posedge hclk);
    conv_valid <= 1'b1;
    conv_dev   <= dev;
    conv_func  <= 3'h3;
    @(posedge hclk);
    conv_valid <= 1'b0;
    @(negedge hclk);
    check("conv_valid_q", 32'h1, {31'h0, conv_valid_q});
    check("conv_func_q", 32'h3, {29'h0, conv_func_q});
    check("conv_dev_q", {27'h0, exp}, {27'h0, conv_dev_q});
  endtask : conv

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // ********************************
  // tests
  // ********************************
  initial begin
    {hresetn, hot_reset, port_is_upstream, hwrite, conv_valid} = 5'h00;
    {retrain_req, deemph_window, link_gen1, low_swing} = 4'h0;
    hsel = 1'b1;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    conv_dev = 5'h00;
    conv_func = 3'h0;
    failures = 0;
    tests_run = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("dcap2", A_DCAP2, 32'h0000_0020);
    rchk("dctl2", A_DCTL2, 32'h0000_0000);
    rchk("dsts2", A_DSTS2, 32'h0000_0000);
    write(A_LCAP2, 32'hFFFF_FFFF);
    rchk("lcap2", A_LCAP2, 32'h0000_0000);
    rchk("lctl2", A_LCTL2, 32'h0000_0002);
    write(A_LCTL2, 32'h0000_0022);
    rchk("lctl2 asd", A_LCTL2, 32'h0000_0002);
    rchk("unmapped", 32'h0000_0004, 32'h0000_0000);
    $display("test reset values done");

    write(A_DCTL2, 32'h0000_0020);
    rchk("dctl2 en", A_DCTL2, 32'h0000_0020);
    conv(5'h05, 5'h05);
    write(A_DCAP2, 32'h0000_0000);
    rchk("dcap2 clr", A_DCAP2, 32'h0000_0000);
    rchk("dctl2 dep", A_DCTL2, 32'h0000_0000);
    write(A_DCTL2, 32'h0000_0020);
    rchk("dctl2 ign", A_DCTL2, 32'h0000_0000);
    conv(5'h05, 5'h00);
    write(A_DCAP2, 32'h0000_0020);
    write(A_LOCK, 32'h0000_0001);
    write(A_DCAP2, 32'h0000_0000);
    rchk("dcap2 lock", A_DCAP2, 32'h0000_0020);
    $display("test forward enable done");

    write(A_LCTL2, 32'h0000_0011);
    write(A_DCTL2, 32'h0000_0020);
    settle(3);
    check("adv cap", 32'h1, {28'h0, speed_adv_cap_q});
    check("compl speed", 32'h1, {28'h0, compliance_speed_q});
    check("compl entry", 32'h1, {31'h0, compliance_entry_q});
    @(posedge hclk);
    retrain_req <= 1'b1;
    @(posedge hclk);
    retrain_req <= 1'b0;
    @(negedge hclk);
    check("chg req", 32'h1, {31'h0, speed_change_req_q});
    check("chg tgt", 32'h1, {28'h0, speed_change_target_q});
    settle(0);
    check("chg req end", 32'h0, {31'h0, speed_change_req_q});
    @(posedge hclk);
    hot_reset <= 1'b1;
    @(posedge hclk);
    hot_reset <= 1'b0;
    rchk("lctl2 hot", A_LCTL2, 32'h0000_0011);
    rchk("dctl2 hot", A_DCTL2, 32'h0000_0000);
    $display("test link control done");

    // lock was dropped by the hot reset, so the select bit is writable
    write(A_LCTL2, 32'h0000_0042);
    settle(3);
    check("tx 35db early", 32'h0, {31'h0, tx_deemph_35db_q});
    check("pref", 32'h1, {31'h0, deemph_pref_q});
    check("active", 32'h1, {31'h0, tx_deemph_active_q});
    @(posedge hclk);
    deemph_window <= 1'b1;
    @(posedge hclk);
    deemph_window <= 1'b0;
    settle(1);
    check("tx 35db", 32'h1, {31'h0, tx_deemph_35db_q});
    @(posedge hclk);
    link_gen1 <= 1'b1;
    settle(2);
    check("active gen1", 32'h0, {31'h0, tx_deemph_active_q});
    @(posedge hclk);
    link_gen1 <= 1'b0;
    low_swing <= 1'b1;
    settle(2);
    check("active swing", 32'h0, {31'h0, tx_deemph_active_q});
    @(posedge hclk);
    low_swing <= 1'b0;
    $display("test de-emphasis done");

    write(A_DCTL2, 32'h0000_0020);
    port_is_upstream <= 1'b1;
    write(A_LCTL2, 32'h0000_0041);
    settle(3);
    check("ari en up", 32'h0, {31'h0, ari_fwd_enable});
    check("adv up", 32'h2, {28'h0, speed_adv_cap_q});
    check("pref up", 32'h1, {31'h0, deemph_pref_q});
    check("active up", 32'h0, {31'h0, tx_deemph_active_q});
    rchk("dcap2 up", A_DCAP2, 32'h0000_0000);
    rchk("dctl2 up", A_DCTL2, 32'h0000_0000);
    conv(5'h07, 5'h00);
    @(posedge hclk);
    port_is_upstream <= 1'b0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("lctl2 cold", A_LCTL2, 32'h0000_0002);
    rchk("dcap2 cold", A_DCAP2, 32'h0000_0020);
    $display("test upstream and reset done");
    close_out();
  end

  // about 150 cycles expected; cut off well beyond that
  initial begin
    #(5000 * 4);
    failures++;
    $display("watchdog expired");
    close_out();
  end

endmodule : port_cap2_regs_test
`default_nettype wire
